// [core/pac_pkg.sv]
// Overview of operation
// RULE1: advertise pause bits 10 and 11 when set
// RULE2: store partner pause bits 10, 11 on capture
// RULE3: MAC reads partner ability and resolves pause
// RULE4: pick highest common advertised mode via pages
// RULE5: at 1000 resolve role, multiport wins master
// RULE6: pause exchange valid only with full duplex
// RULE7: next pages sent from next page transmit register
// RULE8: parallel detect sets bit 5/7, selector 00001
// RULE9: parallel detect: complete set, negotiable reads 0
// RULE10: parallel detect bad link sets fault bit 4
// RULE11: lost negotiated link resumes negotiation
// RULE12: writing control bit 9 restarts negotiation
// RULE13: restart goes quiet until break timer expires
// RULE14: software clears then sets bit 12 to re-enable
// RULE15: strap-disabled negotiation can never be re-enabled
// RULE16: crossover swaps A/B, C/D at 1000, before pages
// RULE17: crossover seed takes 255 distinct values
// RULE18: phy control bit 6 enables automatic crossover
// RULE19: bit 5 picks straight or crossed when manual
// RULE20: crossover at 10/100 regardless of negotiation
// RULE21: shallow loopback in basic control, rest self-test
// RULE22: loopback availability follows speed and interface
// RULE23: break timer length is a design parameter
package pac_pkg;
  localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0] ADDR_ADVERTISE = 5'h04;
  localparam logic [4:0] ADDR_PARTNER = 5'h05;
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_NP_TRANSMIT = 5'h07;
  localparam logic [4:0] ADDR_PHY_CONTROL = 5'h10;
  localparam logic [4:0] ADDR_SELF_TEST = 5'h16;
  localparam int CTL_LOOPBACK = 14;
  localparam int CTL_SPEED_LSB = 13;
  localparam int CTL_AN_ENABLE = 12;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_SPEED_MSB = 6;
  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_ASYM_PAUSE = 11;
  localparam int ADV_PAUSE = 10;
  localparam int ADV_100_FULL = 8;
  localparam int ADV_100_HALF = 7;
  localparam int ADV_10_FULL = 6;
  localparam int ADV_10_HALF = 5;
  localparam int STS_AN_COMPLETE = 5;
  localparam int STS_LINK = 2;
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NEGOTIABLE = 0;
  localparam int PHY_AUTO_XOVER = 6;
  localparam int PHY_FORCE_XOVER = 5;
  localparam logic [4:0] SELECTOR_8023 = 5'h01;
  localparam logic [15:0] CONTROL_RST = 16'h1140;
  localparam logic [15:0] STATUS_CONST = 16'h7948;
  localparam logic [15:0] ADVERTISE_RST = 16'h01E1;
  localparam logic [15:0] NP_TRANSMIT_RST = 16'h2001;
  localparam logic [15:0] PHY_CONTROL_RST = 16'h0040;
  localparam logic [15:0] SELF_TEST_RST = 16'h0000;
  localparam logic [7:0] SEED_RST = 8'h5A;
  localparam int CLK_MHZ = 40;
  localparam int BREAK_LINK_US = 1200;
  localparam int BREAK_LINK_CYC = BREAK_LINK_US * CLK_MHZ;
  localparam int XOVER_SLOT_US = 62;
  localparam int XOVER_SLOT_CYC = XOVER_SLOT_US * CLK_MHZ;
  localparam logic [1:0] SPD_10 = 2'b00;
  localparam logic [1:0] SPD_100 = 2'b01;
  localparam logic [1:0] SPD_1000 = 2'b10;
  typedef enum logic [2:0] {
    LB_NONE = 3'b000, LB_MII = 3'b001, LB_PCS = 3'b010, LB_DIGITAL = 3'b011,
    LB_ANALOG = 3'b100, LB_EXTERNAL = 3'b101, LB_REVERSE = 3'b110
  } pac_loop_t;
  typedef enum logic [2:0] {
    ST_FORCED = 3'b000, ST_BREAK = 3'b001, ST_DETECT = 3'b010,
    ST_NEXT_PAGE = 3'b011, ST_COMPLETE = 3'b100
  } pac_state_t;
endpackage : pac_pkg

// [core/pac_core.sv]
`timescale 1ns/10ps
module pac_core #(
  parameter int BREAK_CYCLES = pac_pkg::BREAK_LINK_CYC,
  parameter int XOVER_CYCLES = pac_pkg::XOVER_SLOT_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic an_strap_disable,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic page_rx_valid,
  input wire logic [15:0] page_rx,
  input wire logic partner_1000_full,
  input wire logic partner_multiport,
  input wire logic [7:0] partner_seed,
  input wire logic local_1000_full,
  input wire logic local_multiport,
  input wire logic pd_link_10,
  input wire logic pd_link_100,
  input wire logic signal_detect,
  input wire logic link_good,
  input wire logic mac_sgmii,
  output logic flp_tx_en,
  output logic [15:0] flp_tx_page,
  output logic tx_quiet,
  output logic an_complete,
  output logic [1:0] link_speed,
  output logic link_full_duplex,
  output logic role_master,
  output logic pause_valid,
  output logic swap_ab,
  output logic swap_cd,
  output pac_pkg::pac_loop_t loop_mode,
  output logic loop_avail,
  output logic loop_link
);
  import pac_pkg::*;

  localparam logic [15:0] BREAK_LOAD = 16'(BREAK_CYCLES - 1);
  localparam logic [15:0] XOVER_LOAD = 16'(XOVER_CYCLES - 1);

  typedef struct packed {
    pac_state_t st;
    logic [15:0] ctl;
    logic [15:0] adv;
    logic [15:0] lpa;
    logic [15:0] ntx;
    logic [15:0] phy;
    logic [15:0] bist;
    logic pd_fault;
    logic lp_neg;
    logic strap_dis;
    logic link_up;
    logic [15:0] tmr;
    logic [15:0] xtmr;
    logic [7:0] seed;
    logic swap;
    logic [1:0] speed;
    logic fdx;
    logic master;
    logic [15:0] rdata;
    logic rvalid;
    pac_loop_t lmode;
    logic lavail;
    logic llink;
    logic o_flp;
    logic [15:0] o_page;
    logic o_quiet;
    logic o_done;
    logic o_role;
    logic o_pause;
    logic o_cd;
  } pac_regs_t;

  pac_regs_t q;
  pac_regs_t d;

  // priority: 1000 full, 100 full, 100 half, 10 full, 10 half
  function automatic logic [3:0] pac_resolve(input logic [15:0] a, input logic [15:0] p,
                                             input logic g_loc, input logic g_lp);
    logic [15:0] c;
    c = a & p;
    if (g_loc && g_lp) pac_resolve = {SPD_1000, 1'b1, 1'b1};
    else if (c[ADV_100_FULL]) pac_resolve = {SPD_100, 1'b1, 1'b1};
    else if (c[ADV_100_HALF]) pac_resolve = {SPD_100, 1'b0, 1'b1};
    else if (c[ADV_10_FULL]) pac_resolve = {SPD_10, 1'b1, 1'b1};
    else if (c[ADV_10_HALF]) pac_resolve = {SPD_10, 1'b0, 1'b1};
    else pac_resolve = {SPD_10, 1'b0, 1'b0};
  endfunction : pac_resolve

  // returns {available, link status} for a loopback mode
  function automatic logic [1:0] pac_loop_ok(input pac_loop_t m, input logic [1:0] s,
                                             input logic sg);
    logic is10;
    is10 = (s == SPD_10);
    case (m)
      LB_NONE: pac_loop_ok = 2'b00;
      LB_MII: pac_loop_ok = {!(sg && is10), 1'b0};
      LB_PCS: pac_loop_ok = {!is10, (s == SPD_100)};
      LB_EXTERNAL: pac_loop_ok = {2{(s != SPD_1000) && !(sg && is10)}};
      default: pac_loop_ok = {2{!(sg && is10)}};
    endcase
  endfunction : pac_loop_ok

  logic an_allowed;
  logic wr_ctl;
  logic restart_req;
  logic [3:0] res;
  logic [1:0] lchk;
  logic pd_any;
  logic pd_bad;

  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    an_allowed = q.ctl[CTL_AN_ENABLE] && !q.strap_dis;
    wr_ctl = reg_wr && (reg_addr == ADDR_BASIC_CONTROL);
    restart_req = wr_ctl && reg_wdata[CTL_AN_RESTART];
    res = pac_resolve(q.adv, page_rx, local_1000_full, partner_1000_full);
    pd_any = pd_link_10 || pd_link_100;
    // two technologies at once, or one we do not advertise, is not a good link
    pd_bad = (pd_link_10 && pd_link_100) ||
             (pd_link_100 && !q.adv[ADV_100_HALF]) ||
             (pd_link_10 && !q.adv[ADV_10_HALF]);

    if (reg_rd) begin
      d.rvalid = 1'b1;
      case (reg_addr)
        ADDR_BASIC_CONTROL: d.rdata = q.ctl;
        ADDR_BASIC_STATUS: begin
          d.rdata = STATUS_CONST;
          d.rdata[STS_AN_COMPLETE] = (q.st == ST_COMPLETE); // [RULE9]
          d.rdata[STS_LINK] = q.link_up;
        end
        ADDR_ADVERTISE: d.rdata = q.adv;
        ADDR_PARTNER: d.rdata = q.lpa;
        ADDR_EXPANSION: begin
          d.rdata = 16'h0004;
          d.rdata[EXP_PD_FAULT] = q.pd_fault;
          d.rdata[EXP_LP_NEGOTIABLE] = q.lp_neg;
          // fault is sticky until read; a new fault in the read cycle survives
          d.pd_fault = 1'b0;
        end
        ADDR_NP_TRANSMIT: d.rdata = q.ntx;
        ADDR_PHY_CONTROL: d.rdata = q.phy;
        ADDR_SELF_TEST: d.rdata = q.bist;
        default: d.rdata = 16'h0000;
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        ADDR_BASIC_CONTROL: begin
          d.ctl = reg_wdata;
          d.ctl[CTL_AN_RESTART] = 1'b0;
          d.ctl[15] = 1'b0;
          if (q.strap_dis) d.ctl[CTL_AN_ENABLE] = 1'b0; // [RULE15]
        end
        ADDR_ADVERTISE: d.adv = {reg_wdata[15:5], SELECTOR_8023}; // [RULE1]
        ADDR_NP_TRANSMIT: d.ntx = reg_wdata; // [RULE7]
        ADDR_PHY_CONTROL: d.phy = reg_wdata; // [RULE18]
        ADDR_SELF_TEST: d.bist = reg_wdata; // [RULE21]
        default: d.rdata = d.rdata;
      endcase
    end

    if (q.tmr != 16'h0000) d.tmr = q.tmr - 16'h0001;

    case (q.st)
      ST_FORCED: begin
        d.speed = {q.ctl[CTL_SPEED_MSB], q.ctl[CTL_SPEED_LSB]};
        d.fdx = q.ctl[CTL_DUPLEX];
        d.link_up = link_good;
        // the clear-then-set sequence lands here as a rising enable
        if (an_allowed) begin // [RULE14]
          d.st = ST_BREAK;
          d.tmr = BREAK_LOAD;
        end
      end
      ST_BREAK: begin
        d.link_up = 1'b0;
        if (q.tmr == 16'h0000) d.st = ST_DETECT; // [RULE13] [RULE23]
      end
      ST_DETECT: begin
        if (page_rx_valid) begin
          d.lpa = page_rx; // [RULE2]
          d.lp_neg = 1'b1;
          d.speed = res[3:2]; // [RULE4]
          d.fdx = res[1];
          // role only matters at 1000; seed breaks a tie between equals
          d.master = (local_multiport != partner_multiport) ? local_multiport :
                     (q.seed > partner_seed); // [RULE5]
          if (q.adv[ADV_NEXT_PAGE] && page_rx[ADV_NEXT_PAGE]) d.st = ST_NEXT_PAGE;
          else d.st = ST_COMPLETE;
        end else if (pd_any) begin
          if (pd_bad) begin
            d.pd_fault = 1'b1; // [RULE10]
          end else begin
            d.lpa = 16'h0000;
            d.lpa[ADV_10_HALF] = pd_link_10; // [RULE8]
            d.lpa[ADV_100_HALF] = pd_link_100;
            d.lpa[4:0] = SELECTOR_8023;
            d.lp_neg = 1'b0; // [RULE9]
            d.speed = pd_link_100 ? SPD_100 : SPD_10;
            d.fdx = 1'b0;
            d.master = 1'b0;
            d.st = ST_COMPLETE;
          end
        end
      end
      ST_NEXT_PAGE: begin
        if (page_rx_valid && !page_rx[ADV_NEXT_PAGE] && !q.ntx[ADV_NEXT_PAGE]) begin
          d.st = ST_COMPLETE; // [RULE7]
        end
      end
      ST_COMPLETE: begin
        if (link_good) d.link_up = 1'b1;
        if (q.link_up && !link_good) begin
          d.link_up = 1'b0;
          d.st = ST_DETECT; // [RULE11]
        end
      end
      default: d.st = ST_FORCED;
    endcase

    if (!an_allowed) begin
      d.st = ST_FORCED;
    end else if (restart_req) begin
      d.st = ST_BREAK; // [RULE12]
      d.tmr = BREAK_LOAD;
      d.link_up = 1'b0;
    end

    // 8-bit maximal LFSR cycles through 255 nonzero seeds
    d.seed = {q.seed[6:0], q.seed[7] ^ q.seed[5] ^ q.seed[4] ^ q.seed[3]}; // [RULE17]
    if (!q.phy[PHY_AUTO_XOVER]) begin
      d.swap = q.phy[PHY_FORCE_XOVER]; // [RULE19]
      d.xtmr = XOVER_LOAD;
    end else if (!signal_detect && !link_good && q.st != ST_NEXT_PAGE) begin
      // hunts in forced mode too, never mid page exchange
      if (q.xtmr == 16'h0000) begin
        d.swap = ~q.swap; // [RULE16] [RULE20]
        d.xtmr = XOVER_LOAD + {8'h00, q.seed};
      end else begin
        d.xtmr = q.xtmr - 16'h0001;
      end
    end

    d.lmode = q.ctl[CTL_LOOPBACK] ? LB_MII : // [RULE21]
              q.bist[5] ? LB_REVERSE : q.bist[4] ? LB_EXTERNAL :
              q.bist[3] ? LB_ANALOG : q.bist[2] ? LB_DIGITAL :
              q.bist[0] ? LB_PCS : LB_NONE;
    lchk = pac_loop_ok(q.lmode, q.speed, mac_sgmii);
    d.lavail = lchk[1]; // [RULE22]
    d.llink = lchk[0];

    if (sys_rst) begin
      d = '0;
      d.st = ST_FORCED;
      d.ctl = CONTROL_RST;
      d.adv = ADVERTISE_RST;
      d.ntx = NP_TRANSMIT_RST;
      d.phy = PHY_CONTROL_RST;
      d.bist = SELF_TEST_RST;
      d.seed = SEED_RST;
      d.xtmr = XOVER_LOAD;
      d.lmode = LB_NONE;
      d.strap_dis = an_strap_disable; // [RULE15]
      if (an_strap_disable) d.ctl[CTL_AN_ENABLE] = 1'b0;
    end

    // status outputs registered from the next state so they keep their old timing
    d.o_flp = (d.st == ST_DETECT) || (d.st == ST_NEXT_PAGE);
    d.o_page = (d.st == ST_NEXT_PAGE) ? d.ntx : d.adv; // [RULE1] [RULE7]
    d.o_quiet = (d.st == ST_BREAK); // [RULE13]
    d.o_done = (d.st == ST_COMPLETE);
    d.o_role = d.master && (d.speed == SPD_1000);
    // the MAC resolves pause itself from the partner register
    d.o_pause = (d.st == ST_COMPLETE) && d.fdx && d.lp_neg; // [RULE6] [RULE3]
    d.o_cd = d.swap && (d.speed == SPD_1000); // [RULE16]
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign flp_tx_en = q.o_flp;
  assign flp_tx_page = q.o_page;
  assign tx_quiet = q.o_quiet;
  assign an_complete = q.o_done;
  assign link_speed = q.speed;
  assign link_full_duplex = q.fdx;
  assign role_master = q.o_role;
  assign pause_valid = q.o_pause;
  assign swap_ab = q.swap;
  assign swap_cd = q.o_cd;
  assign loop_mode = q.lmode;
  assign loop_avail = q.lavail;
  assign loop_link = q.llink;

  adv_pause_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE1]
    reg_wr && reg_addr == ADDR_ADVERTISE |=>
      flp_tx_page[11:10] == $past(reg_wdata[11:10]) || q.st == ST_NEXT_PAGE)
    else $error("advertised pause bits differ from write");
  lp_pause_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE2]
    q.st == ST_DETECT && page_rx_valid && !reg_wr |=> q.lpa[11:10] == $past(page_rx[11:10]))
    else $error("partner pause bits not captured");
  pause_fdx_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE6]
    pause_valid |-> link_full_duplex && an_complete)
    else $error("pause valid without full duplex");
  pd_select_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE8]
    q.st == ST_DETECT && !page_rx_valid && pd_link_100 && !pd_link_10 &&
    q.adv[ADV_100_HALF] && an_allowed && !restart_req
      |=> q.lpa[4:0] == SELECTOR_8023 && q.lpa[ADV_100_HALF] && !q.lp_neg && an_complete)
    else $error("parallel detect result wrong");
  pd_fault_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE10]
    q.st == ST_DETECT && !page_rx_valid && pd_link_10 && pd_link_100 |=> q.pd_fault)
    else $error("parallel detect fault not flagged");
  link_loss_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE11]
    q.st == ST_COMPLETE && q.link_up && !link_good && an_allowed && !restart_req
      |=> q.st == ST_DETECT && flp_tx_en)
    else $error("lost link did not resume negotiation");
  restart_quiet_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE13]
    restart_req && an_allowed |=> tx_quiet && !flp_tx_en ##1 tx_quiet[*3])
    else $error("restart did not silence transmit");
  strap_lock_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE15]
    q.strap_dis |-> q.st == ST_FORCED && !q.ctl[CTL_AN_ENABLE])
    else $error("strap disabled negotiation came back");
  manual_xover_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE19]
    !q.phy[PHY_AUTO_XOVER] && !$past(reg_wr) |=> swap_ab == $past(q.phy[PHY_FORCE_XOVER]))
    else $error("manual crossover not applied");
  loop_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE21]
    q.ctl[CTL_LOOPBACK] |=> loop_mode == LB_MII)
    else $error("shallow loopback not selected");
  loop_pcs_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE22]
    loop_mode == LB_PCS && $stable(q.speed) && q.speed == SPD_10 |=> !loop_avail)
    else $error("pcs loopback shown available at 10M");
endmodule : pac_core

// [bench/pac_partner.sv]
`timescale 1ns/10ps
module pac_partner (
  input wire logic core_clk,
  input wire logic flp_tx_en,
  input wire logic tx_quiet,
  input wire logic cmd_page,
  input wire logic [15:0] cmd_data,
  input wire logic [1:0] cmd_pd,
  input wire logic cmd_link,
  output logic page_rx_valid,
  output logic [15:0] page_rx,
  output logic signal_detect,
  output logic link_good,
  output logic pd_link_10,
  output logic pd_link_100
);
  initial begin
    page_rx_valid = 1'b0;
    page_rx = 16'h0000;
    link_good = 1'b0;
  end
  // a page only lands while the device bursts; idle lines keep changing
  always @(posedge core_clk) begin
    page_rx_valid <= cmd_page && flp_tx_en;
    page_rx <= (cmd_page && flp_tx_en) ? cmd_data : ~page_rx;
    link_good <= cmd_link && !tx_quiet;
  end
  assign pd_link_10 = cmd_pd[0];
  assign pd_link_100 = cmd_pd[1];
  assign signal_detect = cmd_link || (cmd_pd != 2'b00);
endmodule : pac_partner

// [bench/testbench.sv]
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module testbench;
  import pac_pkg::*;
  localparam int BRK = 20;
  localparam int XO = 8;
  int err_count = 0;
  int n_compared = 0;
  int i;
  logic core_clk = 0, sys_rst = 1, strap = 0, reg_wr = 0, reg_rd = 0, s;
  logic [4:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, rv, cmd_data = 0, page_rx, flp_tx_page;
  logic [15:0] seed = 16'h0012;
  logic [15:0] mreg [0:31];
  logic [7:0] pseed = 0;
  logic cmd_page = 0, cmd_link = 0, p1000 = 0, pmp = 0, lmp = 0, sgmii = 0;
  logic [1:0] cmd_pd = 0, link_speed;
  logic reg_rvalid, page_rx_valid, pd10, pd100, sig_det, link_good, flp_tx_en, tx_quiet;
  logic an_complete, link_full_duplex, role_master, pause_valid, swap_ab, loop_avail, loop_link;
  logic swap_cd;
  pac_loop_t loop_mode;
  logic [15:0] lb_ctl [4] = '{16'h4000, 16'h0000, 16'h2000, 16'h0000};
  logic [15:0] lb_st [4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0004};
  logic [4:0] lb_exp [4] = '{5'h06, 5'h08, 5'h0B, 5'h0F};
  logic [4:0] ra [5] = '{5'h00, 5'h04, 5'h07, 5'h10, 5'h16};

  always #12.5 core_clk = ~core_clk;

  pac_core #(.BREAK_CYCLES(BRK), .XOVER_CYCLES(XO)) i_pac_core (.core_clk(core_clk),
    .sys_rst(sys_rst), .an_strap_disable(strap), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .page_rx_valid(page_rx_valid), .page_rx(page_rx), .partner_1000_full(p1000),
    .partner_multiport(pmp), .partner_seed(pseed), .local_1000_full(1'b1),
    .local_multiport(lmp), .pd_link_10(pd10), .pd_link_100(pd100), .signal_detect(sig_det),
    .link_good(link_good), .mac_sgmii(sgmii), .flp_tx_en(flp_tx_en),
    .flp_tx_page(flp_tx_page), .tx_quiet(tx_quiet), .an_complete(an_complete),
    .link_speed(link_speed), .link_full_duplex(link_full_duplex), .role_master(role_master),
    .pause_valid(pause_valid), .swap_ab(swap_ab), .swap_cd(swap_cd), .loop_mode(loop_mode),
    .loop_avail(loop_avail), .loop_link(loop_link));

  pac_partner i_pac_partner (.core_clk(core_clk), .flp_tx_en(flp_tx_en), .tx_quiet(tx_quiet),
    .cmd_page(cmd_page), .cmd_data(cmd_data), .cmd_pd(cmd_pd), .cmd_link(cmd_link),
    .page_rx_valid(page_rx_valid), .page_rx(page_rx), .signal_detect(sig_det),
    .link_good(link_good), .pd_link_10(pd10), .pd_link_100(pd100));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // bit 0 complete, 1 bursting, 2 quiet, 3 pair swap
  task waitf(input int k, input logic v, input int n);
    int j;
    logic [3:0] f;
    f = {swap_ab, tx_quiet, flp_tx_en, an_complete};
    for (j = 0; j < n && f[k] !== v; j++) begin
      cyc(1);
      f = {swap_ab, tx_quiet, flp_tx_en, an_complete};
    end
    if (j == n) begin
      err_count++;
      $display("unexpected wait %0d exp %b got timeout", k, v);
      finish_test;
    end
  endtask : waitf

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge core_clk);
    reg_wr = 0;
    case (a)
      ADDR_BASIC_CONTROL: mreg[a] = d & 16'h7DFF;
      ADDR_ADVERTISE: mreg[a] = {d[15:5], SELECTOR_8023};
      ADDR_NP_TRANSMIT, ADDR_PHY_CONTROL, ADDR_SELF_TEST: mreg[a] = d;
      default: ;
    endcase
  endtask : wr

  task rd(input logic [4:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge core_clk);
    reg_rd = 0;
    `CHK("rvalid", 1'b1, reg_rvalid)
    rv = reg_rdata;
  endtask : rd

  task rdm(input logic [4:0] a);
    rd(a);
    `CHK("reg", mreg[a], rv)
  endtask : rdm

  task do_reset(input logic v);
    strap = v;
    sys_rst = 1;
    cyc(10);
    sys_rst = 0;
    foreach (mreg[j]) mreg[j] = 16'h0000;
    mreg[0] = CONTROL_RST;
    mreg[4] = ADVERTISE_RST;
    mreg[7] = NP_TRANSMIT_RST;
    mreg[16] = PHY_CONTROL_RST;
  endtask : do_reset

  task restart;
    wr(ADDR_BASIC_CONTROL, 16'h1340);
    cyc(BRK - 2);
    `CHK("quiet", 2'b10, {tx_quiet, flp_tx_en})
    waitf(1, 1'b1, 10);
    `CHK("page", mreg[4], flp_tx_page)
  endtask : restart

  // speed, duplex, role and pause validity after a base page
  task neg(input logic [15:0] pg, input logic [1:0] sp, input logic fd, input logic ms);
    restart;
    seed = lfsr(seed);
    pseed = seed[7:0];
    cmd_data = pg;
    cmd_page = 1;
    cyc(1);
    cmd_page = 0;
    waitf(0, 1'b1, 5);
    `CHK("res", {sp, fd, ms, fd}, {link_speed, link_full_duplex, role_master, pause_valid})
    rd(ADDR_PARTNER);
    `CHK("lp_pause", pg[11:10], rv[11:10])
  endtask : neg

  initial begin
    do_reset(0);
    for (i = 0; i < 5; i++) rdm(ra[i]);
    seed = lfsr(seed);
    wr(ADDR_NP_TRANSMIT, seed & 16'h7FFF);
    wr(ADDR_ADVERTISE, 16'h0DE0);
    wr(5'h1F, seed);
    rdm(ADDR_NP_TRANSMIT);
    rdm(ADDR_ADVERTISE);
    rdm(5'h1F);
    waitf(1, 1'b1, BRK + 10);
    $display("test registers done");
    p1000 = 1;
    pmp = 1;
    neg(16'h0D01, SPD_1000, 1'b1, 1'b0);
    pmp = 0;
    lmp = 1;
    neg(16'h0D01, SPD_1000, 1'b1, 1'b1);
    p1000 = 0;
    neg(16'h0081, SPD_100, 1'b0, 1'b0);
    cmd_link = 1;
    cyc(5);
    cmd_link = 0;
    waitf(1, 1'b1, 6);
    $display("test negotiation done");
    restart;
    cmd_pd = 2'b10;
    waitf(0, 1'b1, 2000);
    rd(ADDR_PARTNER);
    `CHK("pd_lp", 16'h0081, rv)
    rd(ADDR_BASIC_STATUS);
    `CHK("pd_done", 1'b1, rv[STS_AN_COMPLETE])
    rd(ADDR_EXPANSION);
    `CHK("pd_lpneg", 1'b0, rv[EXP_LP_NEGOTIABLE])
    cmd_pd = 2'b00;
    restart;
    cmd_pd = 2'b11;
    for (i = 0; i < 40; i++) begin
      rd(ADDR_EXPANSION);
      if (rv[EXP_PD_FAULT]) break;
    end
    `CHK("pd_fault", 1'b1, rv[EXP_PD_FAULT])
    cmd_pd = 2'b00;
    $display("test parallel detect done");
    wr(ADDR_PHY_CONTROL, 16'h0020);
    cyc(2);
    `CHK("swap", 1'b1, swap_ab)
    `CHK("swap_cd", 1'b0, swap_cd)
    wr(ADDR_PHY_CONTROL, 16'h0000);
    cyc(2);
    `CHK("swap", 1'b0, swap_ab)
    wr(ADDR_PHY_CONTROL, 16'h0040);
    rdm(ADDR_PHY_CONTROL);
    s = swap_ab;
    waitf(3, ~s, XO + 300);
    waitf(3, s, XO + 300);
    $display("test crossover done");
    for (i = 0; i < 4; i++) begin
      wr(ADDR_BASIC_CONTROL, lb_ctl[i]);
      wr(ADDR_SELF_TEST, lb_st[i]);
      cyc(3);
      `CHK("loop", lb_exp[i], {loop_mode, loop_avail, loop_link})
    end
    rdm(ADDR_SELF_TEST);
    wr(ADDR_SELF_TEST, 16'h0000);
    wr(ADDR_BASIC_CONTROL, 16'h1000);
    waitf(2, 1'b1, 4);
    waitf(1, 1'b1, BRK + 10);
    $display("test loopback and enable done");
    do_reset(1);
    wr(ADDR_BASIC_CONTROL, 16'h1140);
    cyc(BRK + 5);
    rd(ADDR_BASIC_CONTROL);
    `CHK("strap", 2'b00, {rv[CTL_AN_ENABLE], flp_tx_en})
    $display("test strap done");
    finish_test;
  end
endmodule : testbench
